// file: common/scp_pkg.sv
// Purpose: shared constants for the serial control port
// Assumes: 100 MHz system clock, one data byte per instruction
// Notes: register map is 16 bytes of flip-flops
package scp_pkg;

  // register file shape
  localparam int REG_COUNT = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_OUT_LINE_CTRL = 4'hF;

  // port configuration and output line control register fields
  localparam int CFG_SDIO_BIDIR_BIT = 7;
  localparam int CFG_SOFT_RESET_BIT = 5;
  localparam int OUT_LINE_CLK_SEL_BIT = 0;

  // values after reset
  localparam logic [DATA_W-1:0] REG_DEFAULT = 8'h00;
  localparam logic [DATA_W-1:0] SOFT_RESET_MASK = 8'hDF;

  // instruction byte layout
  localparam int INSTR_READ_BIT = 7;
  localparam int INSTR_ADDR_HI = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  // serial port phases
  typedef enum logic {
    SCP_INSTR,
    SCP_DATA
  } scp_phase_e;

endpackage : scp_pkg

// file: hw/scp_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter and edge pulses
// Assumes: pin is asynchronous to clock_in
// Notes: a change counts once stages two and three agree
module scp_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  // chain; stage1 feeds stage2 only, guarding against metastability
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // filtered level and one-cycle edge pulses
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_out <= RESET_LEVEL;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      if (stage2 == stage3 && stage3 != level_out) begin
        level_out <= stage3;
        rise_out <= stage3;
        fall_out <= !stage3;
      end
    end
  end

endmodule : scp_pin_sync

// file: hw/scp_serial_port.sv
// Purpose: serial control port of the device, configuration registers behind pins
// Assumes: serial clock well below clock_in, sampled as a plain input
// Notes: one instruction byte then one data byte per frame
module scp_serial_port (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic serial_clk_in,
  input wire logic serial_select_n_in,
  input wire logic serial_dio_in,
  input wire logic hw_reset_in,
  input wire logic data_rate_clk_in,
  output logic serial_dio_out,
  output logic serial_dio_oe_out,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  output logic [scp_pkg::REG_COUNT*scp_pkg::DATA_W-1:0] config_regs_out
);
  import scp_pkg::*;

  logic sclk_level;
  logic sclk_rise;
  logic sclk_fall;
  logic select_n;
  logic dio_level;
  logic hw_reset;
  logic rate_clk;
  scp_phase_e phase;
  logic [2:0] bit_cnt;
  logic [DATA_W-1:0] shift_in;
  logic [DATA_W-1:0] instr;
  logic [DATA_W-1:0] out_shift;
  logic [DATA_W-1:0] regs [REG_COUNT];
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_value;
  logic [ADDR_W-1:0] addr;
  logic addr_ok;
  logic active;
  logic io_mode;
  logic clk_sel;
  logic wr_fire;
  logic rd_phase;
  logic rd_drive;

  // all pins pass the three-stage synchroniser
  scp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .pin_in(serial_clk_in),
    .level_out(sclk_level),
    .rise_out(sclk_rise),
    .fall_out(sclk_fall)
  );

  scp_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_select (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .pin_in(serial_select_n_in),
    .level_out(select_n),
    .rise_out(),
    .fall_out()
  );

  scp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_dio (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .pin_in(serial_dio_in),
    .level_out(dio_level),
    .rise_out(),
    .fall_out()
  );

  scp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_hw_reset (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .pin_in(hw_reset_in),
    .level_out(hw_reset),
    .rise_out(),
    .fall_out()
  );

  scp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_rate_clk (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .pin_in(data_rate_clk_in),
    .level_out(rate_clk),
    .rise_out(),
    .fall_out()
  );

  // decoded views of the current frame
  assign active = !select_n && !hw_reset;
  assign io_mode = regs[ADDR_PORT_CFG][CFG_SDIO_BIDIR_BIT];
  assign clk_sel = regs[ADDR_OUT_LINE_CTRL][OUT_LINE_CLK_SEL_BIT];
  assign addr = instr[ADDR_W-1:0];
  assign addr_ok = !instr[INSTR_ADDR_HI];
  assign rd_phase = phase == SCP_DATA && instr[INSTR_READ_BIT];
  assign wr_data = {shift_in[DATA_W-2:0], dio_level};
  assign rd_value = addr_ok ? regs[addr] : REG_DEFAULT;
  assign wr_fire = active && sclk_rise && phase == SCP_DATA && bit_cnt == LAST_BIT &&
                   !instr[INSTR_READ_BIT];

  // frame sequencing; select high drops back to instruction phase
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase <= SCP_INSTR;
      bit_cnt <= FIRST_BIT;
      shift_in <= REG_DEFAULT;
      instr <= REG_DEFAULT;
    end else if (!active) begin
      phase <= SCP_INSTR;
      bit_cnt <= FIRST_BIT;
    end else if (sclk_rise) begin
      shift_in <= wr_data;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == LAST_BIT) begin
        if (phase == SCP_INSTR) begin
          instr <= wr_data;
          phase <= SCP_DATA;
        end else begin
          phase <= SCP_INSTR; // next byte is a fresh instruction
        end
      end
    end
  end

  // register file; soft reset spares the port config register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_DEFAULT;
      end
    end else if (hw_reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_DEFAULT;
      end
    end else if (wr_fire && addr_ok) begin
      if (addr == ADDR_PORT_CFG) begin
        // the reset bit is a trigger, it never stays set
        regs[ADDR_PORT_CFG] <= wr_data & SOFT_RESET_MASK;
        if (wr_data[CFG_SOFT_RESET_BIT]) begin
          for (int i = 1; i < REG_COUNT; i++) begin
            regs[i] <= REG_DEFAULT;
          end
        end
      end else begin
        regs[addr] <= wr_data;
      end
    end
  end

  // read shifter; loads on the fall after the instruction byte
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_shift <= REG_DEFAULT;
    end else if (!active) begin
      out_shift <= REG_DEFAULT;
    end else if (sclk_fall && rd_phase) begin
      if (bit_cnt == FIRST_BIT) begin
        out_shift <= rd_value;
      end else begin
        out_shift <= {out_shift[DATA_W-2:0], 1'b0};
      end
    end
  end

  // separate output line: high-Z in bidirectional mode, else data or clock
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_data_out <= 1'b0;
      serial_data_oe_out <= 1'b0;
    end else begin
      serial_data_oe_out <= !io_mode;
      if (clk_sel) begin
        serial_data_out <= rate_clk;
      end else begin
        serial_data_out <= out_shift[DATA_W-1];
      end
    end
  end

  // turnaround waits for the first fall, by then the host has let go of the line
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_drive <= 1'b0;
    end else if (!active || !rd_phase) begin
      rd_drive <= 1'b0;
    end else if (sclk_fall) begin
      rd_drive <= 1'b1;
    end
  end

  // bidirectional line drives only during a read data byte
  assign serial_dio_out = out_shift[DATA_W-1];
  assign serial_dio_oe_out = io_mode && active && rd_phase && rd_drive;

  // flat register view for the rest of the device
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_flat
    assign config_regs_out[g*DATA_W +: DATA_W] = regs[g];
  end

  // checks kept next to the logic
  AST_OUT_LINE_HIGHZ_IO: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    io_mode && $past(io_mode) |-> !serial_data_oe_out)
    else $error("output line driven in bidirectional mode");

  AST_OUT_LINE_READ_DATA: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    !io_mode && !clk_sel
    |=> serial_data_oe_out && serial_data_out == $past(out_shift[DATA_W-1]))
    else $error("read data missing on output line");

  AST_OUT_LINE_RATE_CLK: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    clk_sel |=> serial_data_out == $past(rate_clk))
    else $error("output line not carrying rate clock");

  AST_DIO_DIRECTION: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    serial_dio_oe_out |-> io_mode && rd_phase)
    else $error("data line driven while input only");

  AST_SAMPLE_ON_RISE: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    active && sclk_rise |=> shift_in[0] == $past(dio_level))
    else $error("data not sampled on serial clock rise");

  AST_OUT_ON_FALL: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    active && $changed(out_shift) |-> $past(sclk_fall))
    else $error("read data changed off a falling edge");

  AST_SELECT_RESETS: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    select_n |=> phase == SCP_INSTR && bit_cnt == FIRST_BIT)
    else $error("select high did not reset port");

  AST_HW_RESET_ALL: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    hw_reset
    |=> regs[ADDR_PORT_CFG] == REG_DEFAULT && regs[ADDR_OUT_LINE_CTRL] == REG_DEFAULT)
    else $error("reset pin left registers set");

  AST_SOFT_RESET: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    wr_fire && addr_ok && addr == ADDR_PORT_CFG && wr_data[CFG_SOFT_RESET_BIT]
    |=> regs[ADDR_OUT_LINE_CTRL] == REG_DEFAULT && !regs[ADDR_PORT_CFG][CFG_SOFT_RESET_BIT])
    else $error("software reset did not clear registers");

  AST_SOFT_KEEPS_CFG: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    wr_fire && addr_ok && addr == ADDR_PORT_CFG && wr_data[CFG_SOFT_RESET_BIT]
    |=> regs[ADDR_PORT_CFG][CFG_SDIO_BIDIR_BIT] == $past(wr_data[CFG_SDIO_BIDIR_BIT]))
    else $error("software reset altered config register");

  AST_INSTR_FIRST: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    active && sclk_rise && phase == SCP_INSTR && bit_cnt == LAST_BIT
    |=> phase == SCP_DATA && instr == $past(wr_data))
    else $error("first byte not taken as instruction");

  AST_WRITE_LANDS: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    wr_fire && addr_ok && addr != ADDR_PORT_CFG |=> regs[$past(addr)] == $past(wr_data))
    else $error("data byte not written to addressed register");

  AST_READ_NO_WRITE: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    phase == SCP_DATA && instr[INSTR_READ_BIT] && !hw_reset |=> $stable(config_regs_out))
    else $error("read instruction altered a register");

  AST_READ_LOAD: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    active && sclk_fall && rd_phase && bit_cnt == FIRST_BIT |=> out_shift == $past(rd_value))
    else $error("read shifter not loaded at first fall");

  AST_READ_SHIFT: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    active && sclk_fall && rd_phase && bit_cnt != FIRST_BIT
    |=> out_shift == {$past(out_shift[DATA_W-2:0]), 1'b0})
    else $error("read shifter did not advance on fall");

  AST_DIO_TURNAROUND: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(serial_dio_oe_out) |-> $past(sclk_fall))
    else $error("data line turned round off a falling edge");

  AST_SELECT_NO_WRITE: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    select_n && !hw_reset |=> $stable(config_regs_out))
    else $error("register written while deselected");

  AST_SOFT_BIT_CLEAR: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    !regs[ADDR_PORT_CFG][CFG_SOFT_RESET_BIT])
    else $error("software reset bit stayed set");

  AST_HW_RESET_IDLE: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    hw_reset |=> phase == SCP_INSTR && bit_cnt == FIRST_BIT && !serial_dio_oe_out)
    else $error("port active during reset pin");

endmodule : scp_serial_port

// file: test/scp_host_model.sv
// Purpose: host controller model driving the serial control pins
// Assumes: serial clock idles low between frames, 125 ns period
// Notes: data set while clock low, read bits taken at each rise
module scp_host_model (
  input wire logic clk_in,
  input wire logic rd_line_in,
  output logic sclk_out,
  output logic sel_n_out,
  output logic dio_out,
  output logic dio_en_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5ns;

  // idle: deselected, clock still, data line released
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    dio_out = 1'b0;
    dio_en_out = 1'b0;
  end

  // one frame of n bits, msb first; fewer than 16 bits aborts it
  task automatic frame(input logic [15:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_in) #1; // pins move just after a system clock edge, never on it
    sel_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      dio_en_out = !(bits[15] && i >= 8); // let go of the line for read data
      dio_out = bits[15 - i]; // valid well before the rise
      #HALF;
      sclk_out = 1'b1;
      rd = {rd[6:0], rd_line_in}; // device moved it at the fall
      #HALF;
      sclk_out = 1'b0;
    end
    #HALF;
    dio_en_out = 1'b0;
    sel_n_out = 1'b1; // high pulse resynchronises the port
    #(4 * HALF);
  endtask : frame
endmodule : scp_host_model

// file: test/serial_control_port_tb_top.sv
// Purpose: self-checking bench for the serial control port
// Assumes: register model kept in the bench, host model drives pins
// Notes: released lines show a toggling level, never a held value
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module serial_control_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import scp_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in, hw_reset_in, data_rate_clk_in;
  logic flt = 1'b0;
  logic sclk, sel_n, host_dio, host_en, dio_out, dio_oe, data_out, data_oe;
  logic dio_wire, rd_line;
  logic [127:0] regs;
  logic [7:0] mdl [16];
  logic [7:0] rd, d;
  logic [3:0] a;
  int errors = 0;
  int check_count = 0;

  scp_serial_port u_scp_serial_port (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .serial_clk_in(sclk), .serial_select_n_in(sel_n), .serial_dio_in(dio_wire),
    .hw_reset_in(hw_reset_in), .data_rate_clk_in(data_rate_clk_in),
    .serial_dio_out(dio_out), .serial_dio_oe_out(dio_oe), .serial_data_out(data_out),
    .serial_data_oe_out(data_oe), .config_regs_out(regs));
  scp_host_model u_scp_host_model (.clk_in(clock_in), .rd_line_in(rd_line), .sclk_out(sclk),
    .sel_n_out(sel_n), .dio_out(host_dio), .dio_en_out(host_en));

  always #5 clock_in = ~clock_in;
  // undriven lines toggle so a stale value cannot pass
  always @(posedge clock_in) flt <= ~flt;
  assign dio_wire = dio_oe ? dio_out : (host_en ? host_dio : flt);
  assign rd_line = data_oe ? data_out : dio_wire;
  // input-only data line is never driven by the device
  always @(negedge clock_in) if (!mdl[0][7]) `CHK(dio_oe, 1'b0)

  task automatic wr(input logic [3:0] wa, input logic [7:0] wd);
    u_scp_host_model.frame({4'h0, wa, wd}, 16, rd);
    mdl[wa] = wd;
  endtask : wr

  task automatic rd_chk(input logic [3:0] ra);
    logic [7:0] v;
    u_scp_host_model.frame({4'h8, ra, 8'h00}, 16, v);
    `CHK(v, mdl[ra])
  endtask : rd_chk

  task automatic chk_all();
    for (int i = 0; i < 16; i++) begin
      `CHK(regs[8*i +: 8], mdl[i])
    end
  endtask : chk_all

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // hang guard
  initial begin
    #300us;
    errors++;
    $display("ERROR t=%0t timeout", $time);
    results();
  end

  initial begin
    rst_b_in = 1'b0;
    hw_reset_in = 1'b0;
    data_rate_clk_in = 1'b0;
    void'($urandom(32'h05e1_67be));
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (5) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    repeat (6) @(posedge clock_in);
    #1 chk_all();
    `CHK(data_oe, 1'b1)
    $display("test reset_defaults done");
    // random traffic, input-only data line, reads on the separate output
    for (int k = 0; k < 20; k++) begin
      a = 4'(1 + $urandom_range(13));
      d = 8'($urandom);
      wr(a, d);
      rd_chk(a);
    end
    wr(4'h0, 8'($urandom) & 8'h5f);
    rd_chk(4'h0);
    chk_all();
    $display("test write_read done");
    // aborts in the instruction and in the data byte must not write
    u_scp_host_model.frame({4'h0, 4'h3, 8'hff}, 5, rd);
    u_scp_host_model.frame({4'h0, 4'h3, 8'h00}, 12, rd);
    rd_chk(4'h3);
    wr(4'h3, 8'ha5);
    rd_chk(4'h3);
    $display("test select_abort done");
    // output line carries the data-rate clock when routed
    wr(4'hf, 8'h01);
    for (int k = 0; k < 6; k++) begin
      @(posedge clock_in) #1 data_rate_clk_in = 1'($urandom);
      repeat (5) @(posedge clock_in);
      #1 `CHK(data_out, data_rate_clk_in)
    end
    $display("test rate_clock done");
    // soft reset keeps config register, clears the rest
    d = (8'($urandom) & 8'h5f) | 8'h20;
    wr(4'h0, d);
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[0] = d & SOFT_RESET_MASK;
    chk_all();
    rd_chk(4'h0);
    $display("test soft_reset done");
    // bidirectional mode: output line released, reads on the data line
    wr(4'h0, 8'h80);
    repeat (2) @(posedge clock_in);
    #1 `CHK(data_oe, 1'b0)
    wr(4'h6, 8'($urandom));
    rd_chk(4'h6);
    rd_chk(4'h0);
    $display("test bidir done");
    // reset pin returns every register, config included
    @(posedge clock_in) #1 hw_reset_in = 1'b1;
    repeat (8) @(posedge clock_in);
    #1 hw_reset_in = 1'b0;
    repeat (6) @(posedge clock_in);
    #1 foreach (mdl[i]) mdl[i] = 8'h00;
    chk_all();
    `CHK(data_oe, 1'b1)
    $display("test reset_pin done");
    results();
  end
endmodule : serial_control_port_tb_top
